// ---- bench/sac_chk.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checks of the sequencer
// ------------------------------------------------------------
module sac_chk (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       sfr_re,
    input wire logic [7:0] sfr_rdata,
    input wire logic       burst_select,
    input wire logic       converter_enable_bit,
    input wire logic       eoc_clear,
    input wire logic       window_clear,
    input wire logic       clk_src_burst,
    input wire logic       sar_step,
    input wire logic       converter_power,
    input wire logic       st_idle,
    input wire logic       st_tracking,
    input wire logic       st_converting,
    input wire logic       end_of_conversion_irq,
    input wire logic       window_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_state_one_hot: assert property (
        $onehot({st_idle, st_tracking, st_converting}))
        else $error("state outputs not one-hot");
    a_clk_source: assert property (
        $stable(burst_select) |-> clk_src_burst == burst_select)
        else $error("clock source does not follow burst select");
    a_power_follow: assert property (
        !burst_select && !$past(burst_select)
        && $stable(converter_enable_bit)
        |-> converter_power == converter_enable_bit)
        else $error("power does not follow enable");
    a_power_burst: assert property (
        burst_select && converter_enable_bit && $past(burst_select)
        && $past(converter_enable_bit) |-> converter_power)
        else $error("power dropped in enabled burst");
    a_irq_hold: assert property (
        end_of_conversion_irq && !eoc_clear |=> end_of_conversion_irq)
        else $error("completion flag lost without clear");
    a_irq_clear: assert property (
        eoc_clear && st_idle |=> !end_of_conversion_irq)
        else $error("completion flag not cleared");
    a_win_hold: assert property (
        window_flag && !window_clear |=> window_flag)
        else $error("window flag lost without clear");
    a_done_idle: assert property (
        $rose(end_of_conversion_irq) |-> ##[0:2] st_idle)
        else $error("no return to idle after group");
    a_idle_no_step: assert property (
        st_idle[*3] |-> !$past(sar_step))
        else $error("sar step while idle");
    a_rdata_hold: assert property (
        !sfr_re |=> $stable(sfr_rdata))
        else $error("read data changed without read");
endmodule

bind sac_top sac_chk i_sac_chk (
    .mclk, .resetn, .sfr_re, .sfr_rdata, .burst_select,
    .converter_enable_bit, .eoc_clear, .window_clear, .clk_src_burst,
    .sar_step, .converter_power, .st_idle, .st_tracking, .st_converting,
    .end_of_conversion_irq, .window_flag
);

// ---- bench/sac_core_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// behavioural sar core
// ------------------------------------------------------------
module sac_core_model (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        st_converting,
    input  wire logic [11:0] sample,
    output logic      [11:0] core_result
);
    logic [11:0] junk;

    // comparator output is noise outside a conversion
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            junk <= 12'hA5A;
        end else begin
            junk <= ~junk;
        end
    end

    assign core_result = st_converting ? sample : junk;
endmodule

// ---- bench/sac_top_test.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// sequencer testbench
// ------------------------------------------------------------
module sac_top_test;
    logic        mclk, resetn, sfr_we, sfr_re, ind_bit0, ind_we;
    logic [7:0]  sfr_addr, sfr_wdata, ind_addr, sfr_rdata;
    logic        convert_start, burst_select, converter_enable_bit;
    logic        left_justify_bit, eoc_clear, window_clear;
    logic [15:0] upper_limit, lower_limit, result;
    logic [11:0] core_result, smp;
    logic        clk_src_burst, sar_step, track_on, converter_power;
    logic        st_idle, st_tracking, st_converting, extra_gain_bit;
    logic [3:0]  repeat_count;
    logic        end_of_conversion_irq, window_flag;
    int          failures, num_checks, cyc, pw, tr, cv, n, d, stp;
    logic [15:0] wu [3] = '{16'h0100, 16'h0300, 16'h0150};
    logic [15:0] wl [3] = '{16'h0300, 16'h0100, 16'h0100};
    logic        wx [3] = '{1'b1, 1'b0, 1'b1};

    sac_top i_sac_top (.mclk, .resetn, .sfr_addr, .sfr_wdata, .sfr_we,
        .sfr_re, .sfr_rdata, .ind_addr, .ind_bit0, .ind_we, .convert_start,
        .burst_select, .converter_enable_bit, .left_justify_bit,
        .upper_limit, .lower_limit, .core_result, .eoc_clear, .window_clear,
        .clk_src_burst, .sar_step, .track_on, .converter_power, .st_idle,
        .st_tracking, .st_converting, .extra_gain_bit, .result,
        .repeat_count, .end_of_conversion_irq, .window_flag);
    sac_core_model i_sac_core_model (.mclk, .resetn, .st_converting,
        .sample(smp), .core_result);

    // 40 MHz clock
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end

    // hang guard, well above the expected run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        chk({15'h0, g}, {15'h0, e});
    endtask

    task automatic chk_rng(input int g, input int lo, input int hi);
        num_checks++;
        if (g < lo || g > hi) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, lo);
        end
    endtask

    // strobes rise one edge after the previous access ended
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        #2 sfr_addr = a;
        sfr_wdata = v;
        sfr_we = 1;
        @(posedge mclk);
        #2 sfr_we = 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        #2 sfr_addr = a;
        sfr_re = 1;
        @(posedge mclk);
        #2 sfr_re = 0;
        chk({8'h00, sfr_rdata}, {8'h00, e});
    endtask

    // only bit 0 exists on the indirect path, upper bits go as zero
    task automatic igw(input logic b);
        @(posedge mclk);
        #2 ind_addr = sac_pkg::EXTRA_GAIN_IADDR;
        ind_bit0 = b;
        ind_we = 1;
        @(posedge mclk);
        #2 ind_we = 0;
    endtask

    task automatic kick();
        @(posedge mclk);
        #2 convert_start = 1;
        @(posedge mclk);
        #2 convert_start = 0;
    endtask

    task automatic clr();
        @(posedge mclk);
        #2 {eoc_clear, window_clear} = 2'b11;
        @(posedge mclk);
        #2 {eoc_clear, window_clear} = 2'b00;
    endtask

    // start one conversion and count cycles of each phase
    task automatic conv();
        pw = 0;
        tr = 0;
        cv = 0;
        stp = 0;
        kick();
        repeat (3000) begin
            if (sar_step) stp++;
            if (st_tracking) tr++;
            else if (st_converting) cv++;
            else if (tr + cv == 0) pw++;
            else break;
            @(posedge mclk);
            #2;
        end
    endtask

    task automatic wait_irq();
        repeat (3000) begin
            if (end_of_conversion_irq !== 1'b1) begin
                @(posedge mclk);
                #2;
            end
        end
    endtask

    // main sequence
    initial begin
        {resetn, sfr_we, sfr_re, ind_bit0, ind_we, convert_start} = '0;
        {burst_select, converter_enable_bit, left_justify_bit} = '0;
        {eoc_clear, window_clear, sfr_addr, sfr_wdata, ind_addr} = '0;
        {upper_limit, lower_limit} = '0;
        smp = 12'h200;
        repeat (16) @(posedge mclk);
        #2 resetn = 1;
        rd(sac_pkg::TRACK_CFG_ADDR, sac_pkg::TRACK_CFG_RST);
        rd(sac_pkg::CONV_CFG_ADDR, sac_pkg::CONV_CFG_RST);
        rd(sac_pkg::EXTRA_GAIN_IADDR, 8'h00);
        wr(8'h55, 8'hAA);
        rd(8'h55, 8'h00);
        chk1(extra_gain_bit, 1'b1);
        igw(1'b0);
        chk1(extra_gain_bit, 1'b1);
        wr(sac_pkg::CONV_CFG_ADDR, 8'h01);
        igw(1'b0);
        chk1(extra_gain_bit, 1'b0);
        igw(1'b1);
        chk1(extra_gain_bit, 1'b1);
        converter_enable_bit = 1;
        wr(sac_pkg::TRACK_CFG_ADDR, 8'h00);
        chk1(converter_power, 1'b1);
        kick();
        repeat (20) @(posedge mclk);
        #2 chk1(st_idle, 1'b1);
        // pre-tracking, divider 0, single conversion
        wr(sac_pkg::TRACK_CFG_ADDR, 8'h08);
        wr(sac_pkg::CONV_CFG_ADDR, 8'h00);
        conv();
        chk_rng(pw, 1, 2);
        chk_rng(tr, 0, 0);
        chk_rng(cv, 15, 16);
        chk_rng(stp, 13, 13);
        chk(result, {4'h0, smp});
        chk1(end_of_conversion_irq, 1'b1);
        clr();
        // left justified single conversion
        left_justify_bit = 1;
        conv();
        chk(result, {smp, 4'h0});
        left_justify_bit = 0;
        // divider for a 15 MHz sar clock, rounded up, from 40 MHz
        d = (40 + 15 - 1) / 15 - 1;
        wr(sac_pkg::CONV_CFG_ADDR, 8'(d << 3));
        conv();
        chk_rng(cv, 13 * (d + 1) + 2, 13 * (d + 1) + 3);
        // post and dual tracking, every track code, divider 1
        wr(sac_pkg::CONV_CFG_ADDR, 8'h08);
        for (int m = 1; m < 4; m += 2) begin
            for (int c = 0; c < 4; c++) begin
                wr(sac_pkg::TRACK_CFG_ADDR, 8'((m << 2) | c));
                conv();
                n = 2 << c;
                chk_rng(tr, n * 2 + 2, n * 2 + 3);
                chk_rng(cv, 28, 29);
                chk_rng(stp, 13, 13);
                repeat (3) @(posedge mclk);
                #2 chk1(track_on, m == 3);
                clr();
            end
        end
        // repeat of four needs four starts outside burst, justify kept 0
        wr(sac_pkg::TRACK_CFG_ADDR, 8'h08);
        wr(sac_pkg::CONV_CFG_ADDR, 8'h02);
        for (int i = 0; i < 4; i++) begin
            conv();
            chk1(end_of_conversion_irq, i == 3);
            chk({12'h000, repeat_count}, 16'((i + 1) % 4));
        end
        chk(result, 16'({smp, 2'b00}));
        clr();
        // enabled burst: one start runs the whole group
        burst_select = 1;
        for (int r = 0; r < 4; r++) begin
            wr(sac_pkg::CONV_CFG_ADDR, 8'(r << 1));
            kick();
            wait_irq();
            n = (r == 0) ? 1 : 2 << r;
            chk(result, 16'(n * smp));
            chk1(converter_power, 1'b1);
            chk1(clk_src_burst, 1'b1);
            clr();
        end
        // burst without enable: sleeps, then (2+1)*8 cycles power-up
        converter_enable_bit = 0;
        wr(sac_pkg::TRACK_CFG_ADDR, 8'h28);
        wr(sac_pkg::CONV_CFG_ADDR, 8'h00);
        chk1(converter_power, 1'b0);
        conv();
        chk_rng(pw, 25, 27);
        repeat (4) @(posedge mclk);
        #2 chk1(converter_power, 1'b0);
        burst_select = 0;
        clr();
        // window limits in both orders
        converter_enable_bit = 1;
        for (int k = 0; k < 3; k++) begin
            upper_limit = wu[k];
            lower_limit = wl[k];
            conv();
            chk1(window_flag, wx[k]);
            clr();
        end
        finish_test();
    end
endmodule

// ---- inc/sac_pkg.sv ----
package sac_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] EXTRA_GAIN_IADDR = 8'h08;
    localparam logic [7:0] TRACK_CFG_ADDR   = 8'hBA;
    localparam logic [7:0] CONV_CFG_ADDR    = 8'hBC;
    localparam logic [7:0] EXTRA_GAIN_RST   = 8'h01;
    localparam logic [7:0] TRACK_CFG_RST    = 8'hFF;
    localparam logic [7:0] CONV_CFG_RST     = 8'hF8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DIV_LSB   = 3;
    localparam int RPT_LSB   = 1;
    localparam int GAIN_PROGRAM_ENABLE_B  = 0;
    localparam int PWR_LSB   = 4;
    localparam int TMODE_LSB = 2;
    localparam int TTIME_LSB = 0;

    // tracking modes
    localparam logic [1:0] TM_RSVD = 2'h0;
    localparam logic [1:0] TM_POST = 2'h1;
    localparam logic [1:0] TM_PRE  = 2'h2;
    localparam logic [1:0] TM_DUAL = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int BURST_OSC_MHZ = 25;
    localparam int PWR_UNIT_NS   = 200;
    localparam int PWR_UNIT_CYC  =
        (PWR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] CONV_SAR_CYC  = 5'h0D;
    localparam logic [1:0] EDGE_SUBSYSTEM_CLOCK_CYC = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PWRUP,
        ST_TRACK,
        ST_CONV
    } sac_state_e;

endpackage

// ---- src/sac_div.sv ----
`timescale 1ns/1ps
// sar clock enable: one pulse every div+1 subsystem clock cycles
module sac_div #(
    parameter int WIDTH = 5
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             clr,
    input  wire logic [WIDTH-1:0] div,
    output logic                  tick
);

    logic [WIDTH-1:0] cnt;

    // elaboration check: a zero-width counter cannot divide
    if (WIDTH < 1) begin : g_width_chk
        $error("sac_div: WIDTH must be at least 1");
    end

    // restart on clr so each phase begins on a whole sar period
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (clr) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == div) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule

// ---- src/sac_top.sv ----
`timescale 1ns/1ps
// converter sequencer: registers, timing, accumulation, window check
module sac_top (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_we,
    input  wire logic        sfr_re,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [7:0]  ind_addr,
    input  wire logic        ind_bit0,
    input  wire logic        ind_we,
    input  wire logic        convert_start,
    input  wire logic        burst_select,
    input  wire logic        converter_enable_bit,
    input  wire logic        left_justify_bit,
    input  wire logic [15:0] upper_limit,
    input  wire logic [15:0] lower_limit,
    input  wire logic [11:0] core_result,
    input  wire logic        eoc_clear,
    input  wire logic        window_clear,
    output logic             clk_src_burst,
    output logic             sar_step,
    output logic             track_on,
    output logic             converter_power,
    output logic             st_idle,
    output logic             st_tracking,
    output logic             st_converting,
    output logic             extra_gain_bit,
    output logic      [15:0] result,
    output logic      [3:0]  repeat_count,
    output logic             end_of_conversion_irq,
    output logic             window_flag
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // sar cycles of the track phase for each track_time_field code
    function automatic logic [4:0] track_sar(input logic [1:0] code);
        logic [4:0] n;
        n = 5'h02;
        unique case (code)
            2'h0: n = 5'h02;
            2'h1: n = 5'h04;
            2'h2: n = 5'h08;
            2'h3: n = 5'h10;
        endcase
        return n;
    endfunction

    // conversions per group, less one
    function automatic logic [3:0] rpt_last(input logic [1:0] code);
        logic [3:0] n;
        n = 4'h0;
        unique case (code)
            2'h0: n = 4'h0;
            2'h1: n = 4'h3;
            2'h2: n = 4'h7;
            2'h3: n = 4'hF;
        endcase
        return n;
    endfunction

    // inside window when lower > upper, outside otherwise
    function automatic logic win_hit(input logic [15:0] v,
                                     input logic [15:0] gt,
                                     input logic [15:0] lt);
        logic h;
        h = 1'b0;
        if (lt > gt) begin
            h = (v > gt) && (v < lt);
        end else begin
            h = (v > gt) || (v < lt);
        end
        return h;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] tracking_config;
    logic [7:0] converter_config;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tracking_config  <= sac_pkg::TRACK_CFG_RST;
            converter_config <= sac_pkg::CONV_CFG_RST;
        end else if (sfr_we) begin
            if (sfr_addr == sac_pkg::TRACK_CFG_ADDR) begin
                tracking_config <= sfr_wdata;
            end
            if (sfr_addr == sac_pkg::CONV_CFG_ADDR) begin
                converter_config <= sfr_wdata;
            end
        end
    end

    // indirect gain write, only bit 0 kept
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            extra_gain_bit <= sac_pkg::EXTRA_GAIN_RST[0];
        end else if (ind_we && converter_config[sac_pkg::GAIN_PROGRAM_ENABLE_B]
                     && ind_addr == sac_pkg::EXTRA_GAIN_IADDR) begin
            extra_gain_bit <= ind_bit0;
        end
    end

    // read port; unmapped addresses and the write-only gain read zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_re) begin
            unique case (sfr_addr)
                sac_pkg::TRACK_CFG_ADDR: sfr_rdata <= tracking_config;
                sac_pkg::CONV_CFG_ADDR:  sfr_rdata <= converter_config;
                default:                 sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic [4:0] sar_divider;
    logic [1:0] repeat_field;
    logic [3:0] powerup_time_field;
    logic [1:0] tracking_mode_field;
    logic [1:0] track_time_field;
    logic [7:0] pwr_cycles;

    assign sar_divider         = converter_config[sac_pkg::DIV_LSB +: 5];
    assign repeat_field        = converter_config[sac_pkg::RPT_LSB +: 2];
    assign powerup_time_field  = tracking_config[sac_pkg::PWR_LSB +: 4];
    assign tracking_mode_field = tracking_config[sac_pkg::TMODE_LSB +: 2];
    assign track_time_field    = tracking_config[sac_pkg::TTIME_LSB +: 2];
    // (field + 1) units of 200 ns
    assign pwr_cycles = 8'((powerup_time_field + 5'h01)
                           * sac_pkg::PWR_UNIT_CYC);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    sac_pkg::sac_state_e state;
    logic       div_clr;
    logic       tick;
    logic [4:0] sar_cnt;
    logic [7:0] pw_cnt;
    logic       phase_done;
    logic [4:0] phase_len;
    logic       start_ok;
    logic       cold;
    logic       first_phase_conv;

    sac_div #(
        .WIDTH (5)
    ) u_div (
        .mclk   (mclk),
        .resetn (resetn),
        .clr    (div_clr),
        .div    (sar_divider),
        .tick   (tick)
    );

    // reserved mode takes no starts; disabled unit only in burst
    assign start_ok = convert_start
                      && tracking_mode_field != sac_pkg::TM_RSVD
                      && (converter_enable_bit || burst_select);
    // power-up wait only when resting in low power
    assign cold = burst_select && !converter_enable_bit;
    assign first_phase_conv = (tracking_mode_field == sac_pkg::TM_PRE);
    // sar cycles of the current phase
    assign phase_len = (state == sac_pkg::ST_CONV)
                       ? sac_pkg::CONV_SAR_CYC
                       : track_sar(track_time_field);
    // restart cycle and tick latency are the 2 subsystem cycles
    // so a phase ends on its last sar tick
    assign phase_done = tick && !div_clr
                        && (sar_cnt == phase_len - 5'h01);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state   <= sac_pkg::ST_IDLE;
            div_clr <= 1'b1;
            pw_cnt  <= 8'h00;
        end else begin
            div_clr <= 1'b0;
            unique case (state)
                sac_pkg::ST_IDLE: begin
                    pw_cnt <= 8'h00;
                    if (start_ok) begin
                        div_clr <= 1'b1;
                        if (cold) begin
                            state <= sac_pkg::ST_PWRUP;
                        end else if (first_phase_conv) begin
                            state <= sac_pkg::ST_CONV;
                        end else begin
                            state <= sac_pkg::ST_TRACK;
                        end
                    end
                end
                sac_pkg::ST_PWRUP: begin
                    pw_cnt <= pw_cnt + 8'h01;
                    if (pw_cnt == pwr_cycles - 8'h01) begin
                        div_clr <= 1'b1;
                        state   <= first_phase_conv ? sac_pkg::ST_CONV
                                                    : sac_pkg::ST_TRACK;
                    end
                end
                sac_pkg::ST_TRACK: begin
                    if (phase_done) begin
                        div_clr <= 1'b1;
                        state   <= sac_pkg::ST_CONV;
                    end
                end
                // burst self-times the group, else wait for a start
                sac_pkg::ST_CONV: begin
                    if (phase_done) begin
                        div_clr <= 1'b1;
                        if (repeat_count == rpt_last(repeat_field)
                            || !burst_select) begin
                            state <= sac_pkg::ST_IDLE;
                        end else begin
                            state <= first_phase_conv ? sac_pkg::ST_CONV
                                                      : sac_pkg::ST_TRACK;
                        end
                    end
                end
            endcase
        end
    end

    // phase counter of sar ticks; held clear outside the timed phases
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sar_cnt <= 5'h00;
        end else if (div_clr || state == sac_pkg::ST_IDLE
                     || state == sac_pkg::ST_PWRUP) begin
            sar_cnt <= 5'h00;
        end else if (tick && sar_cnt != phase_len) begin
            sar_cnt <= sar_cnt + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // accumulation and window
    // ------------------------------------------------------------
    logic        conv_end;
    logic        group_end;
    logic [15:0] sum;

    assign conv_end  = (state == sac_pkg::ST_CONV) && phase_done;
    assign group_end = conv_end && repeat_count == rpt_last(repeat_field);
    // first conversion of a group restarts the sum
    assign sum = (repeat_count == 4'h0) ? {4'h0, core_result}
                 : result + {4'h0, core_result};

    // sum in the result pair; left justify only for single
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            result       <= 16'h0000;
            repeat_count <= 4'h0;
        end else if (conv_end) begin
            if (left_justify_bit && repeat_field == 2'h0) begin
                result <= {core_result, 4'h0};
            end else begin
                result <= sum;
            end
            repeat_count <= group_end ? 4'h0 : repeat_count + 4'h1;
        end
    end

    // flags at group end; a set in the clear cycle wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            end_of_conversion_irq <= 1'b0;
            window_flag           <= 1'b0;
        end else begin
            if (group_end) begin
                end_of_conversion_irq <= 1'b1;
            end else if (eoc_clear) begin
                end_of_conversion_irq <= 1'b0;
            end
            if (group_end && win_hit(
                    (left_justify_bit && repeat_field == 2'h0)
                        ? {core_result, 4'h0} : sum,
                    upper_limit, lower_limit)) begin
                window_flag <= 1'b1;
            end else if (window_clear) begin
                window_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // analog side controls
    // ------------------------------------------------------------
    // registered one cycle behind state; the core tolerates the lag
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clk_src_burst   <= 1'b0;
            sar_step        <= 1'b0;
            track_on        <= 1'b0;
            converter_power <= 1'b0;
            st_idle         <= 1'b1;
            st_tracking     <= 1'b0;
            st_converting   <= 1'b0;
        end else begin
            clk_src_burst <= burst_select;
            // stale tick from the last phase is dropped on restart
            sar_step      <= tick && !div_clr && state == sac_pkg::ST_CONV;
            // power follows enable or a running burst group
            converter_power <= converter_enable_bit
                               || (burst_select && state != sac_pkg::ST_IDLE);
            // track between conversions only in pre and dual
            track_on <= (state == sac_pkg::ST_TRACK)
                        || (state == sac_pkg::ST_IDLE
                            && tracking_mode_field[1]
                            && converter_enable_bit);
            // exactly one state shown; power-up shows as idle
            st_idle       <= state == sac_pkg::ST_IDLE
                             || state == sac_pkg::ST_PWRUP;
            st_tracking   <= state == sac_pkg::ST_TRACK;
            st_converting <= state == sac_pkg::ST_CONV;
        end
    end

endmodule
